// ---- design/eps_pkg.sv ----
// Constants, command codes and field layouts for the endpoint status block.
// Assumes one 25 MHz clock domain and byte-wide commands from the local controller.
//
// Contract
// - Image bit 7 shows endpoint halted
// - Bits 6/5 show second/first buffer full
// - Bit 3 set when unanswered setup replaced
// - Status read of endpoint 0 (code 50) clears bit 3 once storing finished
// - Bit 2 shows buffer holds setup packet
// - Bit 1 shows buffer under processor access
// - Setup arrival locks control buffer commands
// - Acknowledge unlocks addressed control endpoint commands
// - Acknowledge code F4, no data phase
// - Codes A0-AF return endpoint result byte
// - New transaction replaces stored result; toggle bit updated only when ok
// - Result: missed bit7, toggle bit6, ok bit0
// - Fault field bits 4..1 coded outcome
// - Codes D0-DF return image, clear nothing
package eps_pkg;
    localparam int EP_COUNT = 16;
    localparam int EP_IDX_W = 4;
    localparam int BYTE_W = 8;
    // Command codes and command groups (upper nibble selects group)
    localparam logic [7:0] CMD_ACK_SETUP = 8'hf4;
    localparam logic [3:0] CMD_GRP_RESULT = 4'ha;
    localparam logic [3:0] CMD_GRP_IMAGE = 4'hd;
    localparam logic [3:0] CMD_GRP_STATUS_RD = 4'h5;
    // Control endpoint indices
    localparam logic [3:0] EP_CTRL_OUT = 4'h0;
    localparam logic [3:0] EP_CTRL_IN = 4'h1;
    // Status image bit positions
    localparam int IMG_HALT_BIT = 7;
    localparam int IMG_FULL1_BIT = 6;
    localparam int IMG_FULL0_BIT = 5;
    localparam int IMG_CLOB_BIT = 3;
    localparam int IMG_SETUP_BIT = 2;
    localparam int IMG_CPU_SIDE_BUFFER_SEL_BIT = 1;
    // Result byte bit positions
    localparam int RES_MISSED_BIT = 7;
    localparam int RES_TOGGLE_BIT = 6;
    localparam int RES_FAULT_LSB = 1;
    localparam int RES_FAULT_W = 4;
    localparam int RES_OK_BIT = 0;
    // Fault codes
    localparam logic [3:0] FAULT_NONE = 4'h0;
    localparam logic [3:0] FAULT_PID_CHECK = 4'h1;
    localparam logic [3:0] FAULT_PID_UNKNOWN = 4'h2;
    localparam logic [3:0] FAULT_UNEXPECTED = 4'h3;
    localparam logic [3:0] FAULT_TOKEN_CRC = 4'h4;
    localparam logic [3:0] FAULT_DATA_CRC = 4'h5;
    localparam logic [3:0] FAULT_TIMEOUT = 4'h6;
    localparam logic [3:0] FAULT_BABBLE = 4'h7;
    localparam logic [3:0] FAULT_EARLY_EOP = 4'h8;
    localparam logic [3:0] FAULT_NAK = 4'h9;
    localparam logic [3:0] FAULT_HALT_SENT = 4'ha;
    localparam logic [3:0] FAULT_OVERFLOW = 4'hb;
    localparam logic [3:0] FAULT_EMPTY_ISO = 4'hc;
    localparam logic [3:0] FAULT_BIT_STUFF = 4'hd;
    localparam logic [3:0] FAULT_SYNC = 4'he;
    localparam logic [3:0] FAULT_WRONG_TOGGLE = 4'hf;
    // Reset values
    localparam logic [7:0] IMG_RESET = 8'h00;
    localparam logic [7:0] RES_RESET = 8'h00;
    // Command port states
    typedef enum logic [1:0] {
        EPS_ST_IDLE = 2'b01,
        EPS_ST_DATA = 2'b10
    } eps_cmd_state_e;
endpackage

// ---- design/eps_endpoint_status.sv ----
// Endpoint status image, setup handshake and per-endpoint transaction results.
// Assumes the serial engine delivers single-cycle event pulses synchronous to MCLK_I
// and the controller sends one command byte, then at most one data read strobe.
`timescale 1ns/10ps
`default_nettype none
module eps_endpoint_status (
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic CMD_WR_I,
    input wire logic [7:0] CMD_CODE_I,
    input wire logic DATA_RD_I,
    output logic [7:0] RD_DATA_O,
    output logic RD_VALID_O,
    input wire logic [15:0] EP_HALTED_I,
    input wire logic [15:0] EP_FULL1_I,
    input wire logic [15:0] EP_FULL0_I,
    input wire logic [15:0] EP_CPU_BUF_I,
    input wire logic SETUP_START_I,
    input wire logic SETUP_DONE_I,
    input wire logic SETUP_BUF_CLEAR_I,
    input wire logic TXN_DONE_I,
    input wire logic [3:0] TXN_EP_I,
    input wire logic [3:0] TXN_FAULT_I,
    input wire logic TXN_OK_I,
    input wire logic TXN_TOGGLE_I,
    output logic [1:0] BUF_CMD_LOCK_O,
    output logic SETUP_ACK_O
);

    // Command port state
    eps_pkg::eps_cmd_state_e state_r;
    eps_pkg::eps_cmd_state_e state_nxt;
    logic [3:0] sel_ep_r;
    logic [3:0] grp_r;
    logic [7:0] rd_data_r;
    logic rd_valid_r;
    logic ack_r;

    // Setup bookkeeping for the control endpoints
    logic [1:0] lock_r;
    logic setup_pending_r;
    logic storing_r;
    logic holds_setup_r;
    logic clobbered_r;

    // Per-endpoint results and missed_result flags
    logic [7:0] result_r [eps_pkg::EP_COUNT];
    logic [15:0] missed_result_r;

    // Decoded command and read events
    logic cmd_ack;
    logic cmd_sel;
    logic read_go;
    logic read_result;
    logic read_status;
    logic ctrl_halted;
    logic [7:0] image_sel;

    // Command byte decode
    assign cmd_ack = CMD_WR_I && (CMD_CODE_I == eps_pkg::CMD_ACK_SETUP);
    assign cmd_sel = CMD_WR_I && ((CMD_CODE_I[7:4] == eps_pkg::CMD_GRP_RESULT)
        || (CMD_CODE_I[7:4] == eps_pkg::CMD_GRP_IMAGE)
        || (CMD_CODE_I[7:4] == eps_pkg::CMD_GRP_STATUS_RD));

    // Data read taken only after a selecting command
    assign read_go = (state_r == eps_pkg::EPS_ST_DATA) && DATA_RD_I && !CMD_WR_I;
    assign read_result = read_go && (grp_r == eps_pkg::CMD_GRP_RESULT);
    assign read_status = read_go && (grp_r == eps_pkg::CMD_GRP_STATUS_RD);

    // Halting a control endpoint answers the pending setup
    assign ctrl_halted = EP_HALTED_I[eps_pkg::EP_CTRL_OUT] || EP_HALTED_I[eps_pkg::EP_CTRL_IN];

    // Live status image of the selected endpoint
    always_comb begin
        image_sel = eps_pkg::IMG_RESET;
        image_sel[eps_pkg::IMG_HALT_BIT] = EP_HALTED_I[sel_ep_r];
        image_sel[eps_pkg::IMG_FULL1_BIT] = EP_FULL1_I[sel_ep_r];
        image_sel[eps_pkg::IMG_FULL0_BIT] = EP_FULL0_I[sel_ep_r];
        image_sel[eps_pkg::IMG_CPU_SIDE_BUFFER_SEL_BIT] = EP_CPU_BUF_I[sel_ep_r];
        if (sel_ep_r == eps_pkg::EP_CTRL_OUT) begin
            image_sel[eps_pkg::IMG_CLOB_BIT] = clobbered_r;
            image_sel[eps_pkg::IMG_SETUP_BIT] = holds_setup_r;
        end
    end

    // Next command state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            eps_pkg::EPS_ST_IDLE: begin
                if (cmd_sel) begin
                    state_nxt = eps_pkg::EPS_ST_DATA;
                end
            end
            eps_pkg::EPS_ST_DATA: begin
                if (CMD_WR_I) begin
                    state_nxt = cmd_sel ? eps_pkg::EPS_ST_DATA : eps_pkg::EPS_ST_IDLE;
                end else if (DATA_RD_I) begin
                    state_nxt = eps_pkg::EPS_ST_IDLE;
                end
            end
        endcase
    end

    // Command state register
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            state_r <= eps_pkg::EPS_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Endpoint selection from the low nibble of selecting commands
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            sel_ep_r <= eps_pkg::EP_CTRL_OUT;
            grp_r <= 4'h0;
        end else if (cmd_sel) begin
            sel_ep_r <= CMD_CODE_I[3:0];
            grp_r <= CMD_CODE_I[7:4];
        end
    end

    // Read data return, one cycle after the read strobe
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= read_go;
            if (read_result) begin
                rd_data_r <= result_r[sel_ep_r];
            end else if (read_go) begin
                rd_data_r <= image_sel;
            end
        end
    end

    // Setup acknowledge pulse, no data phase follows
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= cmd_ack;
        end
    end

    // Buffer command locks; setup arrival wins over acknowledge
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            lock_r <= 2'b00;
        end else if (SETUP_START_I) begin
            lock_r <= 2'b11;
        end else if (cmd_ack && (sel_ep_r == eps_pkg::EP_CTRL_OUT)) begin
            lock_r[0] <= 1'b0;
        end else if (cmd_ack && (sel_ep_r == eps_pkg::EP_CTRL_IN)) begin
            lock_r[1] <= 1'b0;
        end
    end

    // Setup awaiting acknowledge or halt
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            setup_pending_r <= 1'b0;
        end else if (SETUP_START_I) begin
            setup_pending_r <= 1'b1;
        end else if (cmd_ack || ctrl_halted) begin
            setup_pending_r <= 1'b0;
        end
    end

    // Setup data still being written into the buffer
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            storing_r <= 1'b0;
        end else if (SETUP_START_I) begin
            storing_r <= 1'b1;
        end else if (SETUP_DONE_I) begin
            storing_r <= 1'b0;
        end
    end

    // Buffer holds a setup packet
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            holds_setup_r <= 1'b0;
        end else if (SETUP_DONE_I) begin
            holds_setup_r <= 1'b1;
        end else if (SETUP_BUF_CLEAR_I) begin
            holds_setup_r <= 1'b0;
        end
    end

    // Replaced-setup flag; new setup_clobbered wins over read clear
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            clobbered_r <= 1'b0;
        end else if (SETUP_START_I && setup_pending_r) begin
            clobbered_r <= 1'b1;
        end else if (read_status && (sel_ep_r == eps_pkg::EP_CTRL_OUT) && !storing_r) begin
            clobbered_r <= 1'b0;
        end
    end

    // Per-endpoint result bytes and missed_result flags
    genvar ep;
    generate
        for (ep = 0; ep < eps_pkg::EP_COUNT; ep++) begin : g_ep
            logic hit_txn;
            logic hit_read;
            assign hit_txn = TXN_DONE_I && (TXN_EP_I == 4'(ep));
            assign hit_read = read_result && (sel_ep_r == 4'(ep));

            // Result byte replaced by each transaction, except the toggle bit, which only an ok transaction updates
            always_ff @(posedge MCLK_I) begin
                if (!RESETN_I) begin
                    result_r[ep] <= eps_pkg::RES_RESET;
                end else if (hit_txn) begin
                    result_r[ep][eps_pkg::RES_MISSED_BIT] <= missed_result_r[ep] && !hit_read;
                    if (TXN_OK_I) begin
                        result_r[ep][eps_pkg::RES_TOGGLE_BIT] <= TXN_TOGGLE_I;
                    end
                    result_r[ep][eps_pkg::RES_FAULT_LSB +: eps_pkg::RES_FAULT_W] <= TXN_FAULT_I;
                    result_r[ep][eps_pkg::RES_OK_BIT] <= TXN_OK_I;
                    result_r[ep][5] <= 1'b0;
                end else if (hit_read) begin
                    result_r[ep][eps_pkg::RES_MISSED_BIT] <= 1'b0;
                end
            end

            // Missed_result flag; a new event wins over the read clear
            always_ff @(posedge MCLK_I) begin
                if (!RESETN_I) begin
                    missed_result_r[ep] <= 1'b0;
                end else if (hit_txn) begin
                    missed_result_r[ep] <= 1'b1;
                end else if (hit_read) begin
                    missed_result_r[ep] <= 1'b0;
                end
            end
        end
    endgenerate

    // Outputs straight from flip-flops
    assign RD_DATA_O = rd_data_r;
    assign RD_VALID_O = rd_valid_r;
    assign BUF_CMD_LOCK_O = lock_r;
    assign SETUP_ACK_O = ack_r;

endmodule
`default_nettype wire

// ---- testbench/eps_asserts.sv ----
// Port checks for the endpoint status block.
// Assumes a bind onto eps_endpoint_status, one clock.
`timescale 1ns/10ps
`default_nettype none
module eps_asserts (
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic CMD_WR_I,
    input wire logic [7:0] CMD_CODE_I,
    input wire logic DATA_RD_I,
    input wire logic [7:0] RD_DATA_O,
    input wire logic RD_VALID_O,
    input wire logic [15:0] EP_HALTED_I,
    input wire logic SETUP_START_I,
    input wire logic [1:0] BUF_CMD_LOCK_O,
    input wire logic SETUP_ACK_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESETN_I);
    // Command byte followed by its read strobe
    sequence s_img0;
        CMD_WR_I && CMD_CODE_I == 8'hd0 ##1 DATA_RD_I && !CMD_WR_I;
    endsequence
    sequence s_res;
        CMD_WR_I && CMD_CODE_I[7:4] == 4'ha ##1 DATA_RD_I && !CMD_WR_I;
    endsequence
    a_ack_pulse: assert property (CMD_WR_I && CMD_CODE_I == 8'hf4 |=> SETUP_ACK_O)
        else $error("ack missing");
    a_ack_cause: assert property (SETUP_ACK_O |-> $past(CMD_WR_I) && $past(CMD_CODE_I) == 8'hf4)
        else $error("stray ack");
    a_setup_lock: assert property (SETUP_START_I |=> BUF_CMD_LOCK_O == 2'b11)
        else $error("no lock");
    a_lock_cause: assert property ($rose(BUF_CMD_LOCK_O[0]) |-> $past(SETUP_START_I))
        else $error("stray lock");
    a_unlock_cause: assert property ($fell(BUF_CMD_LOCK_O[0]) || $fell(BUF_CMD_LOCK_O[1]) |-> SETUP_ACK_O)
        else $error("stray unlock");
    a_image_halt: assert property (s_img0 |=> RD_VALID_O && RD_DATA_O[7] == $past(EP_HALTED_I[0])
        && RD_DATA_O[4] == 1'b0 && RD_DATA_O[0] == 1'b0) else $error("bad image");
    a_result_rsvd: assert property (s_res |=> RD_VALID_O && RD_DATA_O[5] == 1'b0)
        else $error("bad result");
    a_valid_cause: assert property (RD_VALID_O |-> $past(DATA_RD_I))
        else $error("stray valid");
endmodule
bind eps_endpoint_status eps_asserts u_chk (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .CMD_WR_I(CMD_WR_I),
    .CMD_CODE_I(CMD_CODE_I), .DATA_RD_I(DATA_RD_I), .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O),
    .EP_HALTED_I(EP_HALTED_I), .SETUP_START_I(SETUP_START_I), .BUF_CMD_LOCK_O(BUF_CMD_LOCK_O),
    .SETUP_ACK_O(SETUP_ACK_O));
`default_nettype wire

// ---- testbench/eps_host_model.sv ----
// Local controller model issuing command bytes and reads.
// Assumes it drives on falling edges of the block clock.
`timescale 1ns/10ps
`default_nettype none
module eps_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i,
    output logic cmd_wr_o,
    output logic [7:0] cmd_code_o,
    output logic data_rd_o
);
    // Idle bus from time zero
    initial begin
        cmd_wr_o = 1'b0;
        cmd_code_o = 8'h00;
        data_rd_o = 1'b0;
    end
    // One command byte for one rising edge
    task automatic put_cmd(input logic [7:0] c);
        @(negedge clk_i);
        cmd_wr_o = 1'b1;
        cmd_code_o = c;
        @(negedge clk_i);
        cmd_wr_o = 1'b0;
    endtask
    // Command, one read strobe, bounded wait for valid
    task automatic get_byte(input logic [7:0] c, output logic [7:0] val);
        int n;
        n = 0;
        put_cmd(c);
        data_rd_o = 1'b1;
        @(negedge clk_i);
        data_rd_o = 1'b0;
        while (rd_valid_i !== 1'b1 && n < 4) begin
            @(negedge clk_i);
            n++;
        end
        val = (rd_valid_i === 1'b1) ? rd_data_i : 8'hxx;
    endtask
    // Status check first, acknowledge only if setup not replaced
    task automatic ack(input logic [3:0] ep, output logic clob);
        logic [7:0] st;
        get_byte({4'h5, ep}, st);
        clob = st[3];
        if (!clob) put_cmd(8'hf4);
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the endpoint status block.
// Assumes the host model drives commands; bench drives engine events.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] halt = '0, full1 = '0, full0 = '0, cpu = '0, tog_r = '0;
    logic [2:0] sev = '0;
    logic txn = 1'b0, tok = 1'b0, ttog = 1'b0, cl;
    logic [3:0] tep = '0, tflt = '0, e;
    logic wr, rd, vld, ack;
    logic [7:0] code, dat, v;
    logic [1:0] lock;
    int num_errors = 0, n_checks = 0;
    // Rows: endpoint, fault, ok, toggle
    logic [11:0] rows [13] = '{12'h003, 12'h110, 12'h240, 12'h350, 12'h460, 12'h570, 12'h690,
        12'h7a0, 12'h8b0, 12'h9d0, 12'hae0, 12'hff0, 12'hf02};
    // Clock, 40 ns period
    always #20 clk = ~clk;
    eps_endpoint_status uut (.MCLK_I(clk), .RESETN_I(rst_n), .CMD_WR_I(wr), .CMD_CODE_I(code),
        .DATA_RD_I(rd), .RD_DATA_O(dat), .RD_VALID_O(vld), .EP_HALTED_I(halt), .EP_FULL1_I(full1),
        .EP_FULL0_I(full0), .EP_CPU_BUF_I(cpu), .SETUP_START_I(sev[0]), .SETUP_DONE_I(sev[1]),
        .SETUP_BUF_CLEAR_I(sev[2]), .TXN_DONE_I(txn), .TXN_EP_I(tep), .TXN_FAULT_I(tflt),
        .TXN_OK_I(tok), .TXN_TOGGLE_I(ttog), .BUF_CMD_LOCK_O(lock), .SETUP_ACK_O(ack));
    eps_host_model host (.clk_i(clk), .rd_data_i(dat), .rd_valid_i(vld), .cmd_wr_o(wr),
        .cmd_code_o(code), .data_rd_o(rd));
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
        host.get_byte(c, v);
        check($sformatf("byte %h", c), v, exp);
    endtask
    task automatic chk3(input logic [7:0] c, input logic b);
        host.get_byte(c, v);
        check("clobbered", {7'h00, v[3]}, {7'h00, b});
    endtask
    // Setup event pulse, one cycle
    task automatic ev(input logic [2:0] k);
        @(negedge clk);
        sev = k;
        @(negedge clk);
        sev = '0;
    endtask
    // Transaction result pulse, one cycle
    task automatic fire(input logic [11:0] r);
        @(negedge clk);
        {tep, tflt, tok, ttog} = {r[11:4], r[1:0]};
        txn = 1'b1;
        @(negedge clk);
        txn = 1'b0;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd_chk(8'ha5, 8'h00);
        {halt, full1, full0, cpu} = {16'h0009, 16'h0008, 16'h0001, 16'h0008};
        rd_chk(8'hd3, 8'hc2);
        rd_chk(8'hd0, 8'ha0);
        halt = '0;
        rd_chk(8'hd3, 8'h42);
        {halt, full1, full0, cpu} = '0;
        foreach (rows[i]) begin
            e = rows[i][11:8];
            fire(rows[i]);
            if (rows[i][1]) tog_r[e] = rows[i][0];
            rd_chk({4'ha, e}, {1'b0, tog_r[e], 1'b0, rows[i][7:4], rows[i][1]});
        end
        fire(12'h590);
        fire(12'h590);
        rd_chk(8'ha5, 8'h92);
        rd_chk(8'ha5, 8'h12);
        ev(3'h1);
        check("lock", {6'h00, lock}, 8'h03);
        ev(3'h2);
        rd_chk(8'hd0, 8'h04);
        ev(3'h1);
        ev(3'h2);
        rd_chk(8'hd0, 8'h0c);
        rd_chk(8'hd0, 8'h0c);
        ev(3'h1);
        chk3(8'h50, 1'b1);
        chk3(8'hd0, 1'b1);
        ev(3'h2);
        rd_chk(8'h50, 8'h0c);
        rd_chk(8'hd0, 8'h04);
        host.ack(4'h0, cl);
        check("ack", {7'h00, ack}, 8'h01);
        check("lock", {6'h00, lock}, 8'h02);
        host.ack(4'h1, cl);
        check("lock", {6'h00, lock}, 8'h00);
        ev(3'h4);
        rd_chk(8'hd0, 8'h00);
        // Halting ctrl OUT answers the setup, so a new one is no setup_clobbered
        ev(3'h1);
        halt = 16'h0001;
        ev(3'h2);
        halt = '0;
        ev(3'h1);
        ev(3'h2);
        rd_chk(8'hd0, 8'h04);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(8'ha0, 8'h00);
        print_verdict();
    end
    // Watchdog against a hang
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
